// ==== cfs_chk.sv ====
// Concurrent checks on the flag word, stack select and interrupt take outputs.
`timescale 1ns/1ps
`default_nettype none
module cfs_chk #(
  parameter int DW = 16
) (
  // Clock, reset and bus handshake.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Core events.
  input wire logic alu_valid,
  input wire logic [3:0] alu_upd_mask,
  input wire logic [DW-1:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_level,
  input wire logic trap_exec,
  input wire logic [5:0] trap_num,
  // State seen by the core.
  input wire logic [10:0] processor_flag_word,
  input wire logic stack_sel_user,
  input wire logic irq_take
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Short aliases keep each property on few lines.
  wire logic [10:0] f = processor_flag_word;
  wire logic u = clk_en && alu_valid;
  // A bus write lands only on the edge where waitrequest is low.
  wire logic bw = avs_write && !avs_waitrequest;
  a_zero_flag: assert property (u && alu_upd_mask[1] |=> f[2] == ($past(alu_result) == '0))
    else $error("zero flag wrong");
  a_sign_flag: assert property (u && alu_upd_mask[2] |=> f[3] == $past(alu_result[DW-1]))
    else $error("sign flag wrong");
  a_carry_flag: assert property (u && alu_upd_mask[0] |=> f[0] == $past(alu_carry))
    else $error("carry flag wrong");
  a_ovf_flag: assert property (u && alu_upd_mask[3] |=> f[5] == $past(alu_overflow))
    else $error("overflow flag wrong");
  a_cond_hold: assert property (clk_en && !alu_valid && !bw |=> f[5:0] == $past(f[5:0]))
    else $error("condition bits moved");
  a_ack_clears: assert property (clk_en && irq_ack |=> f[7:6] == 2'b00 && f[10:8] == $past(irq_ack_level))
    else $error("acknowledge did not clear");
  a_trap_stack: assert property (clk_en && trap_exec && trap_num <= 6'h1f |=> !f[7])
    else $error("low trap kept user stack");
  a_irq_gate: assert property (clk_en |=> irq_take == $past(irq_req && f[6] && irq_level > f[10:8]))
    else $error("interrupt take wrong");
  a_stack_sel: assert property (stack_sel_user == f[7])
    else $error("stack select differs");
  // Main scenarios reached.
  cover property (u && alu_upd_mask == 4'hf);
  cover property (irq_take);
  cover property (clk_en && trap_exec && trap_num <= 6'h1f);
endmodule // cfs_chk
`default_nettype wire

// ==== cfs_defs.svh ====
// Register offsets, field positions and reset values of the flag and base register block.
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH

// Word indices on the register bus.
`define CFS_IDX_SB 3'h0
`define CFS_IDX_FLAG 3'h1
`define CFS_IDX_STAT 3'h2

// Field positions inside the flag word.
`define CFS_FB_C 0
`define CFS_FB_D 1
`define CFS_FB_Z 2
`define CFS_FB_S 3
`define CFS_FB_B 4
`define CFS_FB_O 5
`define CFS_FB_I 6
`define CFS_FB_U 7
`define CFS_FB_IPL_LO 8
`define CFS_FB_IPL_HI 10
`define CFS_FB_RSV 11

// Positions of the update mask bits for condition flags.
`define CFS_UM_C 0
`define CFS_UM_Z 1
`define CFS_UM_S 2
`define CFS_UM_O 3

// Reset values.
`define CFS_RST_SB 16'h0000
`define CFS_RST_FLAG 11'h000
`define CFS_RST_GR 16'h0000

// Highest software trap number that forces the interrupt stack.
`define CFS_TRAP_ISP_MAX 6'h1f

`endif

// ==== cfs_pkg.sv ====
// Types shared by the flag and base register block.
package cfs_pkg;

  // Register bus answer states.
  typedef enum logic [0:0] {
    CFS_BUS_IDLE,
    CFS_BUS_ANSWER
  } cfs_bus_st_t;

endpackage : cfs_pkg

// ==== cfs_regbank.sv ====
// Two banks of general registers selected by the bank select flag.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.svh"

module cfs_regbank
  import cfs_pkg::*;
#(
  parameter int DW = 16,
  parameter int NREG = 7,
  parameter int NBANK = 2
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Bank selection from the flag word.
  input wire logic bank_sel,
  // Core write port.
  input wire logic gr_we,
  input wire logic [2:0] gr_widx,
  input wire logic [DW-1:0] gr_wdata,
  // Core read port, registered.
  input wire logic [2:0] gr_ridx,
  output logic [DW-1:0] gr_rdata_q
);

  // Storage: bank-major, indexed by register number.
  logic [DW-1:0] mem_q [NBANK][NREG];
  // Read selection from the active bank.
  wire [DW-1:0] rd_sel_w;
  wire rd_ok_w;

  assign rd_ok_w = (32'(gr_ridx) < NREG);
  assign rd_sel_w = rd_ok_w ? mem_q[bank_sel][gr_ridx] : '0;

  // Each bank has its own write enable, so only the active bank changes.
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    for (genvar r = 0; r < NREG; r++) begin : g_reg
      wire hit_w;
      assign hit_w = gr_we && (32'(bank_sel) == b) && (32'(gr_widx) == r);
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          mem_q[b][r] <= `CFS_RST_GR;
        end else if (clk_en && hit_w) begin
          mem_q[b][r] <= gr_wdata;
        end
      end
    end
  end

  // Registered read keeps the output straight from a flip-flop.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gr_rdata_q <= `CFS_RST_GR;
    end else if (clk_en) begin
      gr_rdata_q <= rd_sel_w;
    end
  end

endmodule // cfs_regbank
`default_nettype wire

// ==== cfs_top.sv ====
// Processor flag word, static base pointer and banked general registers.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_defs.svh"

module cfs_top
  import cfs_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Avalon-MM slave, word addressed.
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // ALU result and flag update request.
  input wire logic alu_valid,
  input wire logic [3:0] alu_upd_mask,
  input wire logic [DW-1:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  // Interrupt request from the controller.
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  // Acknowledge and trap events from the sequencer.
  input wire logic irq_ack,
  input wire logic [2:0] irq_ack_level,
  input wire logic trap_exec,
  input wire logic [5:0] trap_num,
  // General register port.
  input wire logic gr_we,
  input wire logic [2:0] gr_widx,
  input wire logic [DW-1:0] gr_wdata,
  input wire logic [2:0] gr_ridx,
  output logic [DW-1:0] gr_rdata,
  // State seen by the core.
  output logic [DW-1:0] static_base_pointer,
  output logic [10:0] processor_flag_word,
  output logic stack_sel_user,
  output logic irq_take
);

  // Flag word and static base pointer storage.
  logic [10:0] flag_q;
  logic [10:0] flag_d;
  logic [DW-1:0] sb_q;
  logic [DW-1:0] sb_d;
  // Registered interrupt decision.
  logic irq_take_q;
  // Bus answer machine and its registered outputs.
  cfs_bus_st_t bus_st_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic [31:0] rdata_d;

  // True when the word index matches a register slot.
  function automatic logic idx_is(input logic [2:0] a, input logic [2:0] off);
    idx_is = (a == off);
  endfunction

  // Merge a 16-bit value into old contents under the two low byte enables.
  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0] be);
    be_merge = old;
    if (be[0]) begin
      be_merge[7:0] = nw[7:0];
    end
    if (be[1]) begin
      be_merge[15:8] = nw[15:8];
    end
  endfunction

  // Address decode of the bus request.
  wire hit_sb_w;
  wire hit_flag_w;
  wire hit_stat_w;
  wire any_req_w;
  wire wr_fire_w;
  assign hit_sb_w = idx_is(avs_address, `CFS_IDX_SB);
  assign hit_flag_w = idx_is(avs_address, `CFS_IDX_FLAG);
  assign hit_stat_w = idx_is(avs_address, `CFS_IDX_STAT);
  assign any_req_w = avs_read || avs_write;
  // A write lands at the edge where waitrequest is sampled low.
  assign wr_fire_w = avs_write && (bus_st_q == CFS_BUS_ANSWER);

  // Flag fields written by software, padded to 16 bits for merging.
  wire [15:0] flag_wide_w;
  wire [15:0] flag_wr_w;
  assign flag_wide_w = {5'h00, flag_q};
  assign flag_wr_w = be_merge(flag_wide_w, avs_writedata[15:0], avs_byteenable[1:0]);

  // Condition flag values computed from the ALU result.
  wire res_zero_w;
  wire res_neg_w;
  assign res_zero_w = (alu_result == '0);
  assign res_neg_w = alu_result[DW-1];

  // Interrupt decision: enabled and strictly above the threshold.
  wire ipl_pass_w;
  wire irq_take_d;
  assign ipl_pass_w = irq_level > flag_q[`CFS_FB_IPL_HI:`CFS_FB_IPL_LO];
  assign irq_take_d = irq_req && flag_q[`CFS_FB_I] && ipl_pass_w;

  // A trap with a low number behaves like a hardware entry for the stack flag.
  wire trap_low_w;
  assign trap_low_w = trap_exec && (trap_num <= `CFS_TRAP_ISP_MAX);

  // Next flag word. Software writes first, hardware events override them,
  // so an event in the same cycle as a write is never lost.
  always_comb begin
    flag_d = flag_q;
    if (wr_fire_w && hit_flag_w) begin
      // Bit 11 is reserved and is never stored.
      flag_d = flag_wr_w[10:0];
    end
    if (alu_valid) begin
      // Only flags named by the mask move; the rest keep their value.
      if (alu_upd_mask[`CFS_UM_C]) begin
        flag_d[`CFS_FB_C] = alu_carry;
      end
      if (alu_upd_mask[`CFS_UM_Z]) begin
        flag_d[`CFS_FB_Z] = res_zero_w;
      end
      if (alu_upd_mask[`CFS_UM_S]) begin
        flag_d[`CFS_FB_S] = res_neg_w;
      end
      if (alu_upd_mask[`CFS_UM_O]) begin
        flag_d[`CFS_FB_O] = alu_overflow;
      end
    end
    if (irq_ack) begin
      flag_d[`CFS_FB_I] = 1'b0;
      flag_d[`CFS_FB_U] = 1'b0;
      flag_d[`CFS_FB_IPL_HI:`CFS_FB_IPL_LO] = irq_ack_level;
    end
    if (trap_exec) begin
      // A software trap enters the handler with interrupts closed too.
      flag_d[`CFS_FB_I] = 1'b0;
    end
    if (trap_low_w) begin
      flag_d[`CFS_FB_U] = 1'b0;
    end
  end

  // Next static base pointer; only software changes it.
  always_comb begin
    sb_d = sb_q;
    if (wr_fire_w && hit_sb_w) begin
      sb_d = be_merge(sb_q, avs_writedata[15:0], avs_byteenable[1:0]);
    end
  end

  // Read data mux; the reserved bit and unmapped slots read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_sb_w) begin
      rdata_d = {16'h0000, sb_q};
    end else if (hit_flag_w) begin
      rdata_d = {21'h00_0000, flag_q};
    end else if (hit_stat_w) begin
      rdata_d = {29'h0000_0000, irq_take_q, flag_q[`CFS_FB_U], flag_q[`CFS_FB_B]};
    end
  end

  // Flag word storage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_q <= `CFS_RST_FLAG;
    end else if (clk_en) begin
      flag_q <= flag_d;
    end
  end

  // Static base pointer storage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sb_q <= `CFS_RST_SB;
    end else if (clk_en) begin
      sb_q <= sb_d;
    end
  end

  // Interrupt decision is registered so the output comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_take_q <= 1'b0;
    end else if (clk_en) begin
      irq_take_q <= irq_take_d;
    end
  end

  // Bus answer machine: one wait cycle, then one answer cycle.
  // The wait cycle lets read data come from a flip-flop at the cost of latency.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_st_q <= CFS_BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      case (bus_st_q)
        CFS_BUS_IDLE: begin
          // Capture the answer and drop waitrequest for the next cycle.
          if (any_req_w) begin
            bus_st_q <= CFS_BUS_ANSWER;
            wait_q <= 1'b0;
            rdata_q <= avs_read ? rdata_d : 32'h0000_0000;
          end
        end
        CFS_BUS_ANSWER: begin
          // The master takes the answer at this edge and releases.
          bus_st_q <= CFS_BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_st_q <= CFS_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Banked general registers, selected by the bank flag.
  cfs_regbank #(
    .DW(DW),
    .NREG(7),
    .NBANK(2)
  ) u_bank (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .bank_sel(flag_q[`CFS_FB_B]),
    .gr_we(gr_we),
    .gr_widx(gr_widx),
    .gr_wdata(gr_wdata),
    .gr_ridx(gr_ridx),
    .gr_rdata_q(gr_rdata)
  );

  // Outputs straight from flip-flops.
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign static_base_pointer = sb_q;
  assign processor_flag_word = flag_q;
  assign stack_sel_user = flag_q[`CFS_FB_U];
  assign irq_take = irq_take_q;

endmodule // cfs_top
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the flag word and base pointer block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cfs_pkg::*;
  // Inputs get values at time zero.
  logic clk = 0, rst_b = 0, clk_en = 1, avs_read = 0, avs_write = 0;
  logic [2:0] avs_address = 0, irq_level = 0, irq_ack_level = 0, gr_widx = 6, gr_ridx = 6;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'h3, alu_upd_mask = 0;
  logic alu_valid = 0, alu_carry = 0, alu_overflow = 0, irq_req = 0, irq_ack = 0, trap_exec = 0, gr_we = 0;
  logic [15:0] alu_result = 0, gr_wdata = 0, gr_rdata, static_base_pointer;
  logic [5:0] trap_num = 0;
  logic [10:0] processor_flag_word;
  logic avs_waitrequest, stack_sel_user, irq_take;
  int mismatches = 0, tests_run = 0, cyc = 0;
  // One ALU case: mask, result, carry, overflow, then expected bits 5:0.
  typedef struct {logic [3:0] m; logic [15:0] r; logic c, o; logic [5:0] e;} cfs_row_t;
  // Later rows update only some bits, so the rest must hold.
  cfs_row_t rows[6] = '{'{4'hf, 16'h0000, 1, 0, 6'h05}, '{4'hf, 16'h8000, 0, 1, 6'h28},
    '{4'h1, 16'h0000, 1, 0, 6'h29}, '{4'h2, 16'h0000, 0, 0, 6'h2d},
    '{4'h0, 16'h0000, 0, 1, 6'h2d}, '{4'hc, 16'h1234, 0, 0, 6'h05}};
  cfs_top uut (.*);
  initial forever #5 clk = ~clk;
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus transfer; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  // One ALU pulse, then one edge so the flags have settled.
  task automatic alu(input cfs_row_t x);
    alu_valid <= 1;
    alu_upd_mask <= x.m;
    alu_result <= x.r;
    alu_carry <= x.c;
    alu_overflow <= x.o;
    @(posedge clk);
    alu_valid <= 0;
    @(posedge clk);
  endtask
  // Prints counts and verdict, then stops.
  task automatic print_verdict;
    $display("counts: %0d run, %0d failed", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A hang is cut off well past the expected run of under a hundred cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    chk(processor_flag_word, 0);
    bus(0, 3'h0, 0);
    chk(rd, 0);
    $display("test reset done");
    foreach (rows[i]) begin
      alu(rows[i]);
      chk(processor_flag_word[5:0], rows[i].e);
    end
    $display("test alu done");
    // Readback of both registers; the unmapped index reads zero.
    bus(1, 3'h0, 16'hbeef);
    bus(0, 3'h0, 0);
    chk(rd, 32'h0000_beef);
    // A flag write setting bank select, interrupt enable, user stack and level 3 reads back as written.
    bus(1, 3'h1, 16'h03d0);
    bus(0, 3'h1, 0);
    chk(rd, 32'h0000_03d0);
    chk(stack_sel_user, 1);
    bus(1, 3'h5, 16'hffff);
    bus(0, 3'h5, 0);
    chk(rd, 0);
    $display("test bus done");
    // Level equal to the threshold waits; one above is taken.
    irq_req <= 1;
    irq_level <= 3'h3;
    repeat (2) @(posedge clk);
    chk(irq_take, 0);
    irq_level <= 3'h4;
    repeat (2) @(posedge clk);
    chk(irq_take, 1);
    irq_ack <= 1;
    irq_ack_level <= 3'h5;
    irq_level <= 3'h7;
    @(posedge clk);
    irq_ack <= 0;
    @(posedge clk);
    chk(processor_flag_word[10:6], 5'h14);
    @(posedge clk);
    chk(irq_take, 0);
    irq_req <= 0;
    $display("test irq done");
    // Back-to-back traps: number 32 keeps the user stack, 31 drops it.
    bus(1, 3'h1, 16'h03d0);
    trap_exec <= 1;
    trap_num <= 6'h20;
    @(posedge clk);
    trap_num <= 6'h1f;
    @(posedge clk);
    trap_exec <= 0;
    chk(processor_flag_word[7], 1);
    @(posedge clk);
    chk(processor_flag_word[7], 0);
    $display("test trap done");
    // Same index in each bank holds its own value.
    gr_we <= 1;
    gr_wdata <= 16'h1111;
    @(posedge clk);
    gr_we <= 0;
    bus(1, 3'h1, 16'h0000);
    gr_we <= 1;
    gr_wdata <= 16'h2222;
    @(posedge clk);
    gr_we <= 0;
    repeat (2) @(posedge clk);
    chk(gr_rdata, 16'h2222);
    bus(1, 3'h1, 16'h0010);
    repeat (2) @(posedge clk);
    chk(gr_rdata, 16'h1111);
    // Status word shows bank 1, interrupt stack and no pending take.
    bus(0, 3'h2, 0);
    chk(rd, 32'h0000_0001);
    $display("test bank done");
    print_verdict;
  end
endmodule // tb
bind cfs_top cfs_chk #(.DW(DW)) u_chk (.*);
`default_nettype wire
